// ### core/pfsr_pkg.sv
// Constants and carrier types for the fault status byte block.
// Assumes a byte-wide command port driven by a serial management front end on the same clock.
//
// Overview of operation
// R1: Bit 7 output-voltage byte latches over-voltage fault.
// R2: Bit 4 output-voltage byte latches under-voltage fault.
// R3: Bit 3 latches out-of-limit voltage programming attempts.
// R4: Unsupported flag bits read zero, ignore writes.
// R5: Writing one clears a flag; zero keeps it.
// R6: Only single-byte reads and writes reach these.
// R7: Page 00h selects channel A, 01h channel B.
// R8: Page FFh reads return channel A flags.
// R9: Output-current command read returns selected channel byte.
// R10: Bit 7 output-current byte latches over-current fault.
// R11: Bit 5 output-current byte latches over-current warning.
// R12: Bit 3 output-current byte latches sharing fault.
// R13: Input status read returns input fault byte.
// R14: Input byte is shared, ignores page selection.
// R15: Input byte bits 7,4,3,2,1,0 latch input events.
// R16: Output-voltage byte is paged like output-current byte.
// R17: Flags hold until cleared; set beats clear.
// R18: Read-only bit writes ignored, other flags untouched.
package pfsr_pkg;
   localparam logic [7:0] PFSR_CMD_VOUT = 8'h7A;
   localparam logic [7:0] PFSR_CMD_IOUT = 8'h7B;
   localparam logic [7:0] PFSR_CMD_INPUT = 8'h7C;
   localparam logic [7:0] PFSR_PAGE_A = 8'h00;
   localparam logic [7:0] PFSR_PAGE_B = 8'h01;
   localparam logic [7:0] PFSR_PAGE_ALL = 8'hFF;
   localparam logic [7:0] PFSR_VOUT_MASK = 8'h98;
   localparam logic [7:0] PFSR_IOUT_MASK = 8'hA8;
   localparam logic [7:0] PFSR_INPUT_MASK = 8'h9F;
   localparam logic [7:0] PFSR_FLAGS_RESET = 8'h00;
   localparam int PFSR_BIT_OV = 7;
   localparam int PFSR_BIT_UV = 4;
   localparam int PFSR_BIT_LIMIT = 3;
   localparam int PFSR_BIT_OC = 7;
   localparam int PFSR_BIT_OCW = 5;
   localparam int PFSR_BIT_SHARE = 3;
   localparam int PFSR_BIT_IN_OV = 7;
   localparam int PFSR_BIT_IN_UV = 4;
   localparam int PFSR_BIT_IN_LOW = 3;
   localparam int PFSR_BIT_IN_OC = 2;
   localparam int PFSR_BIT_IN_OCW = 1;
   localparam int PFSR_BIT_IN_OPW = 0;

   // Fault events of one channel, each a one-cycle pulse or level.
   typedef struct packed {
      logic out_overvolt_fault_flag;
      logic out_undervolt_fault_flag;
      logic out_limit_exceeded_flag;
      logic out_overcurrent_fault_flag;
      logic out_overcurrent_warn_flag;
      logic phase_sharing_fault_flag;
   } pfsr_chan_evt_s;

   // Shared input fault events.
   typedef struct packed {
      logic in_overvolt_fault_flag;
      logic in_undervolt_fault_flag;
      logic insufficient_input_off_flag;
      logic in_overcurrent_fault_flag;
      logic in_overcurrent_warn_flag;
      logic in_overpower_warn_flag;
   } pfsr_in_evt_s;

   // Single-byte command from the serial front end.
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] cmd;
      logic [7:0] page;
      logic [7:0] data;
   } pfsr_req_s;
endpackage

// ### core/pfsr_flag_byte.sv
// One latched flag byte with write-one-to-clear and a mask of implemented bits.
// Assumes set events and clear strobes come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module pfsr_flag_byte #(
   parameter logic [7:0] IMPL_MASK = 8'hFF
) (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic reset_n_in,
   // Events and clear
   input wire logic [7:0] set_in,
   input wire logic clr_en_in,
   input wire logic [7:0] clr_data_in,
   // Flags
   output logic [7:0] flags_out
);
   typedef struct packed {
      logic [7:0] flags;
   } pfsr_fb_state_s;

   pfsr_fb_state_s state_q;
   pfsr_fb_state_s state_d;
   logic [7:0] clr_bits;

   always_comb begin
      state_d = state_q;
      clr_bits = clr_en_in ? clr_data_in : 8'h00;
      // Set wins over a clear in the same cycle; unimplemented bits never set.
      state_d.flags = ((state_q.flags & ~clr_bits) | set_in) & IMPL_MASK; // R4 R5 R17 R18
   end

   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         state_q <= '{flags: pfsr_pkg::PFSR_FLAGS_RESET};
      end else begin
         state_q <= state_d;
      end
   end

   assign flags_out = state_q.flags;

   a_flag_holds: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R17
      (!clr_en_in |=> (flags_out & $past(flags_out)) == $past(flags_out)))
      else $error("flag dropped without clear");
   a_set_wins: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R17
      ((set_in & IMPL_MASK) != 8'h00 |=> (flags_out & $past(set_in & IMPL_MASK)) == $past(set_in & IMPL_MASK)))
      else $error("event lost");
   a_unimpl_zero: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R4
      ((flags_out & ~IMPL_MASK) == 8'h00))
      else $error("unsupported bit set");
   a_clear_one: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R5
      (clr_en_in && set_in == 8'h00 |=> (flags_out & $past(clr_data_in)) == 8'h00))
      else $error("write one failed to clear");
endmodule
`default_nettype wire

// ### core/pfsr_status_regs.sv
// Paged output fault bytes and the shared input fault byte.
// Assumes a front end that issues single-byte reads and writes on core_clk_in.
`timescale 1ns/1ps
`default_nettype none
module pfsr_status_regs (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic reset_n_in,
   // Fault events
   input wire pfsr_pkg::pfsr_chan_evt_s evt_a_in,
   input wire pfsr_pkg::pfsr_chan_evt_s evt_b_in,
   input wire pfsr_pkg::pfsr_in_evt_s evt_in_in,
   // Command port
   input wire pfsr_pkg::pfsr_req_s req_in,
   output logic [7:0] rd_data_out,
   output logic rd_valid_out,
   output logic rd_miss_out
);
   typedef struct packed {
      logic [7:0] rd_data;
      logic rd_valid;
      logic rd_miss;
   } pfsr_top_state_s;

   pfsr_top_state_s state_q;
   pfsr_top_state_s state_d;
   logic [7:0] vout_set [2];
   logic [7:0] iout_set [2];
   logic [7:0] input_set;
   logic [7:0] vout_flags [2];
   logic [7:0] iout_flags [2];
   logic [7:0] input_flags;
   logic vout_wr [2];
   logic iout_wr [2];
   logic input_wr;
   logic sel_b;
   logic page_ok;

   function automatic logic [7:0] chan_vout(input pfsr_pkg::pfsr_chan_evt_s e);
      logic [7:0] b;
      b = 8'h00;
      b[pfsr_pkg::PFSR_BIT_OV] = e.out_overvolt_fault_flag; // R1
      b[pfsr_pkg::PFSR_BIT_UV] = e.out_undervolt_fault_flag; // R2
      b[pfsr_pkg::PFSR_BIT_LIMIT] = e.out_limit_exceeded_flag; // R3
      return b;
   endfunction

   function automatic logic [7:0] chan_iout(input pfsr_pkg::pfsr_chan_evt_s e);
      logic [7:0] b;
      b = 8'h00;
      b[pfsr_pkg::PFSR_BIT_OC] = e.out_overcurrent_fault_flag; // R10
      b[pfsr_pkg::PFSR_BIT_OCW] = e.out_overcurrent_warn_flag; // R11
      b[pfsr_pkg::PFSR_BIT_SHARE] = e.phase_sharing_fault_flag; // R12
      return b;
   endfunction

   always_comb begin
      input_set = 8'h00;
      input_set[pfsr_pkg::PFSR_BIT_IN_OV] = evt_in_in.in_overvolt_fault_flag; // R15
      input_set[pfsr_pkg::PFSR_BIT_IN_UV] = evt_in_in.in_undervolt_fault_flag;
      input_set[pfsr_pkg::PFSR_BIT_IN_LOW] = evt_in_in.insufficient_input_off_flag;
      input_set[pfsr_pkg::PFSR_BIT_IN_OC] = evt_in_in.in_overcurrent_fault_flag;
      input_set[pfsr_pkg::PFSR_BIT_IN_OCW] = evt_in_in.in_overcurrent_warn_flag;
      input_set[pfsr_pkg::PFSR_BIT_IN_OPW] = evt_in_in.in_overpower_warn_flag;
   end

   assign vout_set[0] = chan_vout(evt_a_in);
   assign vout_set[1] = chan_vout(evt_b_in);
   assign iout_set[0] = chan_iout(evt_a_in);
   assign iout_set[1] = chan_iout(evt_b_in);

   // Page 01h picks channel B; 00h and FFh pick channel A.
   assign sel_b = (req_in.page == pfsr_pkg::PFSR_PAGE_B); // R7 R8 R16
   assign page_ok = (req_in.page == pfsr_pkg::PFSR_PAGE_A) || sel_b || (req_in.page == pfsr_pkg::PFSR_PAGE_ALL);

   // A write with page FFh clears both channels, as a broadcast.
   always_comb begin
      for (int c = 0; c < 2; c++) begin
         vout_wr[c] = req_in.wr && req_in.cmd == pfsr_pkg::PFSR_CMD_VOUT &&
                      (req_in.page == pfsr_pkg::PFSR_PAGE_ALL || sel_b == (c == 1)) && page_ok; // R5 R16
         iout_wr[c] = req_in.wr && req_in.cmd == pfsr_pkg::PFSR_CMD_IOUT &&
                      (req_in.page == pfsr_pkg::PFSR_PAGE_ALL || sel_b == (c == 1)) && page_ok; // R5 R7
      end
      input_wr = req_in.wr && req_in.cmd == pfsr_pkg::PFSR_CMD_INPUT; // R14
   end

   for (genvar c = 0; c < 2; c++) begin : g_chan
      pfsr_flag_byte #(.IMPL_MASK(pfsr_pkg::PFSR_VOUT_MASK)) u_vout (
         .core_clk_in(core_clk_in),
         .reset_n_in(reset_n_in),
         .set_in(vout_set[c]),
         .clr_en_in(vout_wr[c]),
         .clr_data_in(req_in.data),
         .flags_out(vout_flags[c])
      );
      pfsr_flag_byte #(.IMPL_MASK(pfsr_pkg::PFSR_IOUT_MASK)) u_iout (
         .core_clk_in(core_clk_in),
         .reset_n_in(reset_n_in),
         .set_in(iout_set[c]),
         .clr_en_in(iout_wr[c]),
         .clr_data_in(req_in.data),
         .flags_out(iout_flags[c])
      );
   end

   pfsr_flag_byte #(.IMPL_MASK(pfsr_pkg::PFSR_INPUT_MASK)) u_input (
      .core_clk_in(core_clk_in),
      .reset_n_in(reset_n_in),
      .set_in(input_set),
      .clr_en_in(input_wr),
      .clr_data_in(req_in.data),
      .flags_out(input_flags)
   );

   // Single-byte reads answer one cycle after the request.
   always_comb begin
      state_d = state_q;
      state_d.rd_valid = req_in.rd; // R6
      state_d.rd_miss = 1'b0;
      state_d.rd_data = 8'h00;
      if (req_in.rd) begin
         case (req_in.cmd)
            pfsr_pkg::PFSR_CMD_VOUT: begin
               state_d.rd_data = vout_flags[sel_b]; // R16 R8
               state_d.rd_miss = !page_ok;
            end
            pfsr_pkg::PFSR_CMD_IOUT: begin
               state_d.rd_data = iout_flags[sel_b]; // R9 R7 R8
               state_d.rd_miss = !page_ok;
            end
            pfsr_pkg::PFSR_CMD_INPUT: begin
               state_d.rd_data = input_flags; // R13 R14
            end
            default: begin
               state_d.rd_miss = 1'b1;
            end
         endcase
         if (state_d.rd_miss) begin
            state_d.rd_data = 8'h00;
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         state_q <= '{rd_data: 8'h00, rd_valid: 1'b0, rd_miss: 1'b0};
      end else begin
         state_q <= state_d;
      end
   end

   assign rd_data_out = state_q.rd_data;
   assign rd_valid_out = state_q.rd_valid;
   assign rd_miss_out = state_q.rd_miss;

   // Reads answer on the next edge with the flags that stood when the request was taken.
   a_read_iout_b: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R7
      (req_in.rd && req_in.cmd == pfsr_pkg::PFSR_CMD_IOUT && req_in.page == pfsr_pkg::PFSR_PAGE_B
       |=> rd_valid_out && rd_data_out == $past(iout_flags[1])))
      else $error("channel B current byte misread");
   a_read_iout_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R9
      (req_in.rd && req_in.cmd == pfsr_pkg::PFSR_CMD_IOUT && req_in.page == pfsr_pkg::PFSR_PAGE_A
       |=> rd_valid_out && rd_data_out == $past(iout_flags[0])))
      else $error("channel A current byte misread");
   a_read_vout_b: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R16
      (req_in.rd && req_in.cmd == pfsr_pkg::PFSR_CMD_VOUT && req_in.page == pfsr_pkg::PFSR_PAGE_B
       |=> rd_valid_out && rd_data_out == $past(vout_flags[1])))
      else $error("channel B voltage byte misread");
   a_read_all_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R8
      (req_in.rd && req_in.cmd == pfsr_pkg::PFSR_CMD_VOUT && req_in.page == pfsr_pkg::PFSR_PAGE_ALL
       |=> rd_data_out == $past(vout_flags[0])))
      else $error("page FFh did not read channel A");
   a_input_shared: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R14
      (req_in.rd && req_in.cmd == pfsr_pkg::PFSR_CMD_INPUT |=> !rd_miss_out && rd_data_out == $past(input_flags)))
      else $error("input byte depends on page");
   a_read_pulse: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R6
      (req_in.rd |=> rd_valid_out))
      else $error("read not answered");
   a_no_stray: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R6
      (!req_in.rd |=> !rd_valid_out))
      else $error("answer without a read");
   a_miss_zero: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R6
      (rd_miss_out |-> rd_valid_out && rd_data_out == 8'h00))
      else $error("refused read returned data");
   a_bad_page_miss: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R7
      (req_in.rd && req_in.cmd == pfsr_pkg::PFSR_CMD_IOUT && !page_ok |=> rd_miss_out && rd_data_out == 8'h00))
      else $error("unknown page not refused");

   // Writes on a refused page leave both channels alone; input clears ignore the page.
   a_page_write: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R7
      (req_in.wr && !page_ok && evt_a_in == '0 && evt_b_in == '0
       |=> vout_flags[0] == $past(vout_flags[0]) && iout_flags[0] == $past(iout_flags[0])
           && vout_flags[1] == $past(vout_flags[1]) && iout_flags[1] == $past(iout_flags[1])))
      else $error("refused page write changed a flag");
   a_input_clear: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R14
      (req_in.wr && req_in.cmd == pfsr_pkg::PFSR_CMD_INPUT && evt_in_in == '0
       |=> (input_flags & $past(req_in.data)) == 8'h00))
      else $error("input clear depends on page");

   // Each event shows in its byte on the next edge.
   a_ov_latch: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R1
      (evt_a_in.out_overvolt_fault_flag |=> vout_flags[0][pfsr_pkg::PFSR_BIT_OV]))
      else $error("over-voltage not latched");
   a_ov_latch_b: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R1
      (evt_b_in.out_overvolt_fault_flag |=> vout_flags[1][pfsr_pkg::PFSR_BIT_OV]))
      else $error("channel B over-voltage not latched");
   a_uv_latch: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R2
      (evt_b_in.out_undervolt_fault_flag |=> vout_flags[1][pfsr_pkg::PFSR_BIT_UV]))
      else $error("under-voltage not latched");
   a_limit_latch: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R3
      (evt_a_in.out_limit_exceeded_flag |=> vout_flags[0][pfsr_pkg::PFSR_BIT_LIMIT]))
      else $error("limit attempt not latched");
   a_oc_latch: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R10
      (evt_b_in.out_overcurrent_fault_flag |=> iout_flags[1][pfsr_pkg::PFSR_BIT_OC]))
      else $error("over-current not latched");
   a_ocw_latch: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R11
      (evt_a_in.out_overcurrent_warn_flag |=> iout_flags[0][pfsr_pkg::PFSR_BIT_OCW]))
      else $error("over-current warning not latched");
   a_share_latch: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R12
      (evt_b_in.phase_sharing_fault_flag |=> iout_flags[1][pfsr_pkg::PFSR_BIT_SHARE]))
      else $error("sharing fault not latched");
   a_in_ov_latch: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R15
      (evt_in_in.in_overvolt_fault_flag |=> input_flags[pfsr_pkg::PFSR_BIT_IN_OV]))
      else $error("input over-voltage not latched");
   a_in_low_latch: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R15
      (evt_in_in.insufficient_input_off_flag |=> input_flags[pfsr_pkg::PFSR_BIT_IN_LOW]))
      else $error("low input not latched");
endmodule
`default_nettype wire

// ### testbench/pfsr_host_model.sv
// Host model that issues single-byte status reads and writes.
// Assumes the status block takes a request on the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module pfsr_host_model (
   // Clock
   input wire logic core_clk_in,
   // Request
   output var pfsr_pkg::pfsr_req_s req_out
);
   initial req_out = '0;
   // Changes just after an edge and holds until the next edge takes it.
   task automatic xfer(input logic rd, input logic wr, input logic [7:0] cmd, input logic [7:0] page,
      input logic [7:0] data);
      @(posedge core_clk_in);
      req_out <= {rd, wr, cmd, page, data};
   endtask
   // Released lines show the inverse of their last value.
   task automatic idle();
      @(posedge core_clk_in);
      req_out <= {2'b00, ~req_out[23:0]};
   endtask
endmodule
`default_nettype wire

// ### testbench/pfsr_status_regs_tb.sv
// Self-checking bench for the fault status byte block.
// Assumes the host model drives requests and a queue-free reference model tracks flags.
`timescale 1ns/1ps
`default_nettype none
module pfsr_status_regs_tb;
   logic core_clk_in = 1'b0;
   logic reset_n_in = 1'b0;
   pfsr_pkg::pfsr_chan_evt_s ea = '0;
   pfsr_pkg::pfsr_chan_evt_s eb = '0;
   pfsr_pkg::pfsr_in_evt_s ei = '0;
   pfsr_pkg::pfsr_req_s r;
   logic [7:0] rd_data, inp, exp_data;
   logic [7:0] vo [2];
   logic [7:0] io [2];
   logic rd_valid, rd_miss, exp_valid, exp_miss, ok;
   int bad_count = 0;
   int tests_run = 0;
   logic [7:0] pages [4] = '{8'h00, 8'h01, 8'hFF, 8'h02};

   always #20 core_clk_in = ~core_clk_in;

   pfsr_host_model u_pfsr_host_model (.core_clk_in(core_clk_in), .req_out(r));
   pfsr_status_regs u_pfsr_status_regs (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
      .evt_a_in(ea), .evt_b_in(eb), .evt_in_in(ei), .req_in(r), .rd_data_out(rd_data),
      .rd_valid_out(rd_valid), .rd_miss_out(rd_miss));

   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp1(input logic got, input logic exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic conclude();
      if (bad_count == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Every command on every page, back to back.
   task automatic sweep(input logic rd, input logic wr, input logic [7:0] data);
      for (int c = 0; c < 4; c++) begin
         for (int p = 0; p < 4; p++) begin
            u_pfsr_host_model.xfer(rd, wr, 8'h7A + 8'(c), pages[p], data);
         end
      end
      u_pfsr_host_model.idle();
   endtask

   // Reference model: reads see the flags before this edge's clears and sets.
   always @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         vo = '{default: 8'h00};
         io = '{default: 8'h00};
         inp = 8'h00;
         exp_valid = 1'b0;
      end else begin
         ok = r.page == 8'h00 || r.page == 8'h01 || r.page == 8'hFF;
         exp_valid = r.rd;
         exp_miss = r.rd && r.cmd != 8'h7C && !(ok && (r.cmd == 8'h7A || r.cmd == 8'h7B));
         exp_data = 8'h00;
         if (r.rd && !exp_miss) begin
            exp_data = r.cmd == 8'h7A ? vo[r.page == 8'h01] : r.cmd == 8'h7B ? io[r.page == 8'h01] : inp;
         end
         for (int c = 0; c < 2; c++) begin
            if (r.wr && (r.page == 8'hFF || r.page == 8'(c))) begin
               if (r.cmd == 8'h7A) vo[c] &= ~r.data;
               if (r.cmd == 8'h7B) io[c] &= ~r.data;
            end
         end
         if (r.wr && r.cmd == 8'h7C) inp &= ~r.data;
         vo[0] |= {ea[5], 2'b00, ea[4], ea[3], 3'b000};
         vo[1] |= {eb[5], 2'b00, eb[4], eb[3], 3'b000};
         io[0] |= {ea[2], 1'b0, ea[1], 1'b0, ea[0], 3'b000};
         io[1] |= {eb[2], 1'b0, eb[1], 1'b0, eb[0], 3'b000};
         inp |= {ei[5], 2'b00, ei[4:0]};
      end
   end

   always @(negedge core_clk_in) begin
      if (reset_n_in === 1'b1) begin
         cmp1(rd_valid, exp_valid);
         if (exp_valid) begin
            cmp1(rd_miss, exp_miss);
            cmp8(rd_data, exp_data);
         end
      end
   end

   initial begin
      repeat (20000) @(posedge core_clk_in);
      bad_count++;
      conclude();
   end

   initial begin
      void'($urandom(86));
      repeat (20) @(posedge core_clk_in);
      reset_n_in <= 1'b1;
      sweep(1'b1, 1'b0, 8'h00);
      for (int b = 0; b < 12; b++) begin
         @(posedge core_clk_in);
         {ea, eb} <= 12'h001 << b;
         ei <= 6'h01 << (b % 6);
         @(posedge core_clk_in);
         {ea, eb, ei} <= '0;
         sweep(1'b1, 1'b0, 8'h00);
      end
      sweep(1'b0, 1'b1, 8'h00);
      sweep(1'b0, 1'b1, 8'h47);
      sweep(1'b1, 1'b0, 8'h00);
      u_pfsr_host_model.xfer(1'b0, 1'b1, 8'h7A, 8'h00, 8'hFF);
      ea <= '1;
      u_pfsr_host_model.idle();
      ea <= '0;
      sweep(1'b0, 1'b1, 8'hFF);
      sweep(1'b1, 1'b0, 8'h00);
      for (int i = 0; i < 3000; i++) begin
         // Nothing is requested or raised on the two edges that the mid-run reset holds.
         u_pfsr_host_model.xfer((i == 1500 || i == 1501) ? 1'b0 : 1'($urandom),
            (i == 1500 || i == 1501) ? 1'b0 : 1'($urandom), 8'h7A + 8'($urandom % 4), pages[$urandom % 4],
            8'($urandom));
         {ea, eb, ei} <= ($urandom % 8 == 0 && (i < 1500 || i > 1501)) ? 18'($urandom) : 18'h0;
         if (i == 1500) reset_n_in <= 1'b0;
         if (i == 1502) reset_n_in <= 1'b1;
      end
      sweep(1'b1, 1'b0, 8'h00);
      conclude();
   end
endmodule
`default_nettype wire
